// file: sms_cfg.svh
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

// register byte offsets on the APB side
`define SMS_OFF_STATUS    4'h0
`define SMS_OFF_CTRL1     4'h4
`define SMS_OFF_CTRL2     4'h8
`define SMS_OFF_DATA      4'hC

// serial_status_control fields
`define SMS_ST_ENABLE     15
`define SMS_ST_IDLE_STOP  13
`define SMS_ST_OVERFLOW   6
`define SMS_ST_TX_FULL    1
`define SMS_ST_RX_FULL    0

// serial_control_one fields
`define SMS_C1_CLK_DIS    12
`define SMS_C1_OUT_DIS    11
`define SMS_C1_WORD16     10
`define SMS_C1_SAMPLE_END 9
`define SMS_C1_EDGE       8
`define SMS_C1_SEL_EN     7
`define SMS_C1_POL        6
`define SMS_C1_MASTER     5
`define SMS_C1_SEC_LSB    2
`define SMS_C1_PRI_LSB    0
`define SMS_C1_MASK       16'h1FFF

// serial_control_two fields
`define SMS_C2_FRAMED     15
`define SMS_C2_FS_DIR     14
`define SMS_C2_FS_POL     13
`define SMS_C2_FS_EDGE    1

// reset values
`define SMS_REG_RESET     16'h0000
`define SMS_WORD_RESET    32'h0000_0000

// word lengths, prescale base and frame sync lead
`define SMS_BITS_WORD     5'h10
`define SMS_BITS_BYTE     5'h08
`define SMS_SEC_BASE      4'h8
`define SMS_FRAME_HALVES  6'h01

`endif

// file: sms_pkg.sv
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_IDLE,
    SMS_FRAME,
    SMS_SHIFT
  } sms_state_t;

endpackage

// file: sms_clk_prescale.sv
`timescale 1ns/1ps
`include "sms_cfg.svh"

module sms_clk_prescale
  import sms_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic [1:0] primary_prescale_i,
  input  wire logic [2:0] secondary_prescale_i,
  output logic            half_tick_o
);

  logic [3:0] sec_ratio;
  logic [2:0] pri_shift;
  logic [9:0] divisor;
  logic [9:0] count_r;

  always_comb begin
    sec_ratio = `SMS_SEC_BASE - {1'b0, secondary_prescale_i};
    // primary ratio as power of four
    pri_shift = {~primary_prescale_i, 1'b0};
    // full period is the product of both ratios
    divisor   = {6'h00, sec_ratio} << pri_shift;
  end

  // restarts with every run so the first edge has a fixed delay
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= 10'h000;
    end else if (!run_i) begin
      count_r <= 10'h000;
    end else if (count_r >= divisor - 10'h001) begin
      count_r <= 10'h000;
    end else begin
      count_r <= count_r + 10'h001;
    end
  end

  // two ticks per serial clock period; odd products above one give an uneven duty
  assign half_tick_o = run_i && ((count_r == 10'h000) || (count_r == (divisor >> 1)));

endmodule

// file: sms_serial_port.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "sms_cfg.svh"

module sms_serial_port
  import sms_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              idle_mode_i,
  input  wire logic              serial_clock_i,
  output logic                   serial_clock_o,
  output logic                   serial_clock_oe_o,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_o,
  input  wire logic              serial_in_i,
  input  wire logic              slave_select_i,
  output logic                   slave_select_o,
  output logic                   slave_select_oe_o,
  output logic                   transfer_irq_o,
  output logic                   error_irq_o
);

  if (ADDR_W < 4) begin : g_check
    $error("ADDR_W must be at least 4");
  end

  // software-visible state
  logic        port_enable_r;
  logic        idle_stop_r;
  logic        receive_overflow_r;
  logic        transmit_buffer_full_r;
  logic        receive_buffer_full_r;
  logic [12:0] ctrl1_r;
  logic        framed_enable_r;
  logic        frame_sync_direction_r;
  logic        frame_sync_polarity_r;
  logic        frame_sync_edge_r;
  logic [15:0] transmit_holding_r;
  logic [15:0] receive_holding_r;
  logic [31:0] prdata_r;

  // transfer engine state
  sms_state_t  state_r;
  logic [5:0]  half_r;
  logic        sck_r;
  logic [15:0] tx_shift_r;
  logic [15:0] rx_shift_r;
  logic        sck_prev_r;
  logic [4:0]  slave_cnt_r;
  logic        slave_started_r;
  logic        fs_seen_r;
  logic        irq_done_r;
  logic        irq_err_r;

  // APB decode
  logic        mapped;
  logic        acc_write;
  logic        acc_read;
  logic        wr_status;
  logic        wr_ctrl1;
  logic        wr_ctrl2;
  logic        wr_data;
  logic        rd_data;
  logic [15:0] rd_value;

  always_comb begin
    mapped = ((paddr_i >> 4) == '0) && (paddr_i[1:0] == 2'h0);
    acc_write = psel_i && penable_i && pwrite_i && mapped;
    acc_read  = psel_i && penable_i && !pwrite_i && mapped;
    wr_status = acc_write && (paddr_i[3:0] == `SMS_OFF_STATUS);
    wr_ctrl1  = acc_write && (paddr_i[3:0] == `SMS_OFF_CTRL1);
    wr_ctrl2  = acc_write && (paddr_i[3:0] == `SMS_OFF_CTRL2);
    wr_data   = acc_write && (paddr_i[3:0] == `SMS_OFF_DATA);
    rd_data   = acc_read && (paddr_i[3:0] == `SMS_OFF_DATA);
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // configuration views
  logic       run;
  logic       master;
  logic       word16;
  logic [4:0] nbits;
  logic [5:0] nhalves;
  logic       edge_late;
  logic       sample_end;
  logic       polarity;
  logic       halt;
  logic       fs_in_active;
  logic       start_ok;

  always_comb begin
    run = port_enable_r && !(idle_stop_r && idle_mode_i);
    master = ctrl1_r[`SMS_C1_MASTER];
    word16 = ctrl1_r[`SMS_C1_WORD16];
    nbits = word16 ? `SMS_BITS_WORD : `SMS_BITS_BYTE;
    nhalves = {nbits, 1'b0};
    // framed operation ignores the edge bit
    edge_late = ctrl1_r[`SMS_C1_EDGE] && !framed_enable_r;
    // sample phase in master mode only
    sample_end = master && ctrl1_r[`SMS_C1_SAMPLE_END];
    polarity = ctrl1_r[`SMS_C1_POL];
    // stalled while overflow stands and buffer unread
    halt = receive_overflow_r && receive_buffer_full_r;
    fs_in_active = (slave_select_i == frame_sync_polarity_r);
    start_ok = !(framed_enable_r && frame_sync_direction_r) || fs_seen_r || fs_in_active;
  end

  // master clock divider
  logic tick;

  sms_clk_prescale u_prescale (
    .clock_i              (clock_i),
    .reset_n_i            (reset_n_i),
    .run_i                (run && master && (state_r != SMS_IDLE)),
    .primary_prescale_i   (ctrl1_r[`SMS_C1_PRI_LSB +: 2]),
    .secondary_prescale_i (ctrl1_r[`SMS_C1_SEC_LSB +: 3]),
    .half_tick_o          (tick)
  );

  // transfer events
  logic m_tick;
  logic m_change;
  logic m_sample;
  logic m_done;
  logic m_start;
  logic s_edge;
  logic s_lead;
  logic s_trail;
  logic s_sel;
  logic s_live;
  logic s_change;
  logic s_sample;
  logic s_done;
  logic s_load;
  logic change_ev;
  logic sample_ev;
  logic done_ev;
  logic load_ev;
  logic rx_full_now;
  logic [15:0] rx_next;

  always_comb begin
    m_tick = run && master && (state_r == SMS_SHIFT) && tick && !halt;
    // output change edge; 2N half periods
    m_change = m_tick && (edge_late ? (half_r[0] && (half_r < nhalves - 6'h01))
                                    : (!half_r[0] && (half_r != 6'h00) && (half_r < nhalves)));
    // middle or end of output time
    m_sample = m_tick && (sample_end ? (edge_late ? half_r[0] : (!half_r[0] && (half_r != 6'h00)))
                                     : (edge_late ? (!half_r[0] && (half_r < nhalves)) : half_r[0]));
    m_done = m_tick && (half_r == nhalves);
    m_start = run && master && transmit_buffer_full_r && start_ok &&
              ((state_r == SMS_IDLE) || m_done);

    s_edge  = serial_clock_i != sck_prev_r;
    s_lead  = s_edge && (serial_clock_i != polarity);
    s_trail = s_edge && (serial_clock_i == polarity);
    // select pin only when enabled; frame sync input
    if (framed_enable_r) begin
      s_sel = !frame_sync_direction_r || fs_seen_r || fs_in_active || slave_started_r;
    end else begin
      s_sel = !ctrl1_r[`SMS_C1_SEL_EN] || !slave_select_i;
    end
    s_live = run && !master && s_sel && !halt;
    // slave change edge, first bit presented at load
    s_change = s_live && (edge_late ? s_trail : (s_lead && slave_started_r));
    s_sample = s_live && (edge_late ? s_lead : s_trail);
    s_done = s_sample && (slave_cnt_r == nbits - 5'h01);
    s_load = run && !master && transmit_buffer_full_r &&
             ((!slave_started_r && (slave_cnt_r == 5'h00)) || s_done);

    change_ev = master ? m_change : s_change;
    sample_ev = master ? m_sample : s_sample;
    done_ev   = master ? m_done : s_done;
    load_ev   = master ? m_start : s_load;
    rx_next   = sample_ev ? {rx_shift_r[14:0], serial_in_i} : rx_shift_r;
    rx_full_now = receive_buffer_full_r && !rd_data;
  end

  // APB register writes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_enable_r          <= 1'b0;
      idle_stop_r            <= 1'b0;
      ctrl1_r                <= 13'h0000;
      framed_enable_r        <= 1'b0;
      frame_sync_direction_r <= 1'b0;
      frame_sync_polarity_r  <= 1'b0;
      frame_sync_edge_r      <= 1'b0;
      transmit_holding_r     <= `SMS_REG_RESET;
    end else begin
      if (wr_status) begin
        port_enable_r <= pwdata_i[`SMS_ST_ENABLE];
        idle_stop_r   <= pwdata_i[`SMS_ST_IDLE_STOP];
      end
      if (wr_ctrl1) begin
        ctrl1_r <= pwdata_i[12:0];
      end
      if (wr_ctrl2) begin
        framed_enable_r        <= pwdata_i[`SMS_C2_FRAMED];
        frame_sync_direction_r <= pwdata_i[`SMS_C2_FS_DIR];
        frame_sync_polarity_r  <= pwdata_i[`SMS_C2_FS_POL];
        frame_sync_edge_r      <= pwdata_i[`SMS_C2_FS_EDGE];
      end
      if (wr_data) begin
        transmit_holding_r <= word16 ? pwdata_i[15:0] : {8'h00, pwdata_i[7:0]};
      end
    end
  end

  // status flags; a hardware set wins over a same-cycle clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      transmit_buffer_full_r <= 1'b0;
      receive_buffer_full_r  <= 1'b0;
      receive_overflow_r     <= 1'b0;
      receive_holding_r      <= `SMS_REG_RESET;
    end else begin
      // full on write, empty on move to shifter
      if (wr_data) begin
        transmit_buffer_full_r <= 1'b1;
      end else if (load_ev) begin
        transmit_buffer_full_r <= 1'b0;
      end
      // discard when unread; receive full; move to buffer
      if (done_ev && !rx_full_now) begin
        receive_buffer_full_r <= 1'b1;
        receive_holding_r     <= word16 ? rx_next : {8'h00, rx_next[7:0]};
      end else if (rd_data) begin
        receive_buffer_full_r <= 1'b0;
      end
      if (done_ev && rx_full_now) begin
        receive_overflow_r <= 1'b1;
      end else if (wr_status && !pwdata_i[`SMS_ST_OVERFLOW]) begin
        receive_overflow_r <= 1'b0;
      end
    end
  end

  // master sequencer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= SMS_IDLE;
      half_r  <= 6'h00;
    end else if (!run || !master) begin
      state_r <= SMS_IDLE;
      half_r  <= 6'h00;
    end else begin
      case (state_r)
        SMS_IDLE: begin
          half_r <= 6'h00;
          if (m_start) begin
            // sync one bit ahead when edge bit clear
            state_r <= (framed_enable_r && !frame_sync_direction_r && !frame_sync_edge_r) ?
                       SMS_FRAME : SMS_SHIFT;
          end
        end
        SMS_FRAME: begin
          if (tick && (half_r == `SMS_FRAME_HALVES)) begin
            state_r <= SMS_SHIFT;
            half_r  <= 6'h00;
          end else if (tick) begin
            half_r <= half_r + 6'h01;
          end
        end
        SMS_SHIFT: begin
          if (m_done) begin
            half_r  <= 6'h00;
            state_r <= m_start ? SMS_SHIFT : SMS_IDLE;
          end else if (m_tick) begin
            half_r <= half_r + 6'h01;
          end
        end
        default: begin
          state_r <= SMS_IDLE;
          half_r  <= 6'h00;
        end
      endcase
    end
  end

  // master clock level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_r <= 1'b0;
    end else if (state_r != SMS_SHIFT) begin
      sck_r <= polarity;
    end else if (m_tick && (half_r < nhalves)) begin
      sck_r <= ~sck_r;
    end
  end

  // slave edge tracking
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_prev_r      <= 1'b0;
      slave_cnt_r     <= 5'h00;
      slave_started_r <= 1'b0;
    end else begin
      sck_prev_r <= serial_clock_i;
      if (!run || master || !s_sel || s_done) begin
        slave_cnt_r     <= 5'h00;
        slave_started_r <= 1'b0;
      end else if (s_live) begin
        if (s_sample) begin
          slave_cnt_r <= slave_cnt_r + 5'h01;
        end
        if (s_lead) begin
          slave_started_r <= 1'b1;
        end
      end
    end
  end

  // frame sync capture for frame-slave operation
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fs_seen_r <= 1'b0;
    end else if (run && framed_enable_r && frame_sync_direction_r && fs_in_active) begin
      fs_seen_r <= 1'b1;
    end else if (done_ev || m_start || !run) begin
      fs_seen_r <= 1'b0;
    end
  end

  // shift registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift_r <= `SMS_REG_RESET;
      rx_shift_r <= `SMS_REG_RESET;
    end else begin
      if (load_ev) begin
        tx_shift_r <= transmit_holding_r;
      end else if (change_ev) begin
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      end
      if (done_ev || load_ev) begin
        rx_shift_r <= `SMS_REG_RESET;
      end else if (sample_ev) begin
        rx_shift_r <= rx_next;
      end
    end
  end

  // interrupt pulses
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_done_r <= 1'b0;
      irq_err_r  <= 1'b0;
    end else begin
      irq_done_r <= done_ev;
      irq_err_r  <= done_ev && rx_full_now;
    end
  end

  assign transfer_irq_o = irq_done_r;
  assign error_irq_o    = irq_err_r;

  // read data captured in the setup phase
  always_comb begin
    case (paddr_i[3:0])
      `SMS_OFF_STATUS: rd_value = {port_enable_r, 1'b0, idle_stop_r, 6'h00, receive_overflow_r,
                                   4'h0, transmit_buffer_full_r, receive_buffer_full_r};
      `SMS_OFF_CTRL1:  rd_value = {3'h0, ctrl1_r};
      `SMS_OFF_CTRL2:  rd_value = {framed_enable_r, frame_sync_direction_r,
                                   frame_sync_polarity_r, 11'h000, frame_sync_edge_r, 1'b0};
      `SMS_OFF_DATA:   rd_value = receive_holding_r;
      default:         rd_value = `SMS_REG_RESET;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r <= `SMS_WORD_RESET;
    end else if (psel_i && !penable_i) begin
      prdata_r <= mapped ? {16'h0000, rd_value} : `SMS_WORD_RESET;
    end
  end

  assign prdata_o = prdata_r;

  // pin drivers
  logic fs_out_active;

  always_comb begin
    if (master) begin
      fs_out_active = (state_r == SMS_FRAME) ||
                      ((state_r == SMS_SHIFT) && frame_sync_edge_r && (half_r < 6'h02));
    end else begin
      fs_out_active = (slave_started_r || s_lead) && (slave_cnt_r == 5'h00);
    end
  end

  assign serial_clock_o    = sck_r;
  assign serial_clock_oe_o = run && master && !ctrl1_r[`SMS_C1_CLK_DIS];
  assign serial_out_o      = word16 ? tx_shift_r[15] : tx_shift_r[7];
  assign serial_out_oe_o   = run && !ctrl1_r[`SMS_C1_OUT_DIS] &&
                             (master || framed_enable_r || !ctrl1_r[`SMS_C1_SEL_EN] ||
                              !slave_select_i);
  assign slave_select_o    = frame_sync_polarity_r ? fs_out_active : !fs_out_active;
  assign slave_select_oe_o = run && framed_enable_r && !frame_sync_direction_r;

endmodule

// file: sms_assertions.sv
`timescale 1ns/1ps
`include "sms_cfg.svh"
module sms_checker #(
  parameter int ADDR_W = 4
)
(
  input wire logic              clock_i,
  input wire logic              reset_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              idle_mode_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              serial_clock_oe_o,
  input wire logic              serial_out_oe_o,
  input wire logic              transfer_irq_o,
  input wire logic              error_irq_o
);
  logic [15:0] c1_r;
  logic        en_r;
  logic        is_r;
  logic        live;
  logic        wr_go;
  // the port only runs while enabled and not stopped by idle mode
  assign live = en_r && !(is_r && idle_mode_i);
  assign wr_go = psel_i && penable_i && pwrite_i && (paddr_i[1:0] == 2'h0);
  // shadow copy, so pin enables can be judged without seeing inside
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c1_r <= 16'h0000;
      en_r <= 1'b0;
      is_r <= 1'b0;
    end else if (wr_go && paddr_i == `SMS_OFF_CTRL1) begin
      c1_r <= pwdata_i[15:0];
    end else if (wr_go && paddr_i == `SMS_OFF_STATUS) begin
      en_r <= pwdata_i[`SMS_ST_ENABLE];
      is_r <= pwdata_i[`SMS_ST_IDLE_STOP];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_high: assert property (pready_o)
    else $error("pready low");
  a_bad_addr: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("misaligned access not refused");
  a_good_addr: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped access refused");
  a_err_rdata: assert property (psel_i && !penable_i && !pwrite_i && paddr_i[1:0] != 2'h0
    |=> prdata_o == 32'h0) else $error("refused read returned data");
  a_rdata_upper: assert property (prdata_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_irq_pulse: assert property (transfer_irq_o |=> !transfer_irq_o)
    else $error("transfer irq longer than one cycle");
  a_err_pulse: assert property (error_irq_o |=> !error_irq_o)
    else $error("error irq longer than one cycle");
  a_clk_oe: assert property (serial_clock_oe_o == (live && c1_r[5] && !c1_r[12]))
    else $error("clock enable wrong");
  a_out_oe: assert property (!live || c1_r[11] |-> !serial_out_oe_o)
    else $error("data out driven while released");
  c_xfer: cover property (transfer_irq_o);
  c_err: cover property (error_irq_o);
  c_refuse: cover property (pslverr_o);
endmodule

bind sms_serial_port sms_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .idle_mode_i(idle_mode_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_clock_oe_o(serial_clock_oe_o),
  .serial_out_oe_o(serial_out_oe_o), .transfer_irq_o(transfer_irq_o),
  .error_irq_o(error_irq_o));

// file: sms_peer.sv
`timescale 1ns/1ps
module sms_peer (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        sck_i,
  input  wire logic        sdo_i,
  input  wire logic        load_i,
  input  wire logic [15:0] word_i,
  output logic             sdi_o,
  output logic [15:0]      rx_o
);
  logic        prev_r;
  logic [15:0] tx_r;
  assign sdi_o = tx_r[15];
  // shift on idle edge
  // spent bits refill inverted so stale data never matches by luck
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_r <= 16'h0000;
    end else if (load_i) begin
      tx_r <= word_i;
    end else if (!sck_i && prev_r) begin
      tx_r <= {tx_r[14:0], ~tx_r[15]};
    end
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_o <= 16'h0000;
      prev_r <= 1'b0;
    end else begin
      prev_r <= sck_i;
      if (sck_i && !prev_r) begin
        rx_o <= {rx_o[14:0], sdo_i};
      end
    end
  end
endmodule

// file: test_sms_serial_port.sv
`timescale 1ns/1ps
`include "sms_cfg.svh"
`define CHK(n, x, g) begin num_checks++; if ((g) !== (x)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, x, g); end end
module test_sms_serial_port;
  logic        clock_i, reset_n_i, psel, penable, pwrite, idle, ld, e, ssck, ssel;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] pw, prx;
  logic        pready, pslverr, sck, sck_oe, sdo, sdo_oe, sdi, ss_o, ss_oe, tirq, eirq;
  int          error_cnt, num_checks, tg, per, fs, ei, ti;
  sms_serial_port dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .idle_mode_i(idle),
    .serial_clock_i(ssck), .serial_clock_o(sck), .serial_clock_oe_o(sck_oe),
    .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .serial_in_i(sdi),
    .slave_select_i(ssel), .slave_select_o(ss_o), .slave_select_oe_o(ss_oe),
    .transfer_irq_o(tirq), .error_irq_o(eirq));
  sms_peer peer (.clock_i(clock_i), .reset_n_i(reset_n_i), .sck_i(sck | ssck), .sdo_i(sdo),
    .load_i(ld), .word_i(pw), .sdi_o(sdi), .rx_o(prx));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int i;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock_i);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin `CHK("pready", 1, 0) test_done(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x, input string n);
    apb(1'b0, a, 16'h0000);
    `CHK(n, {16'h0000, x}, q)
  endtask
  task automatic cfg(input logic [15:0] c1, input logic [15:0] c2);
    apb(1'b1, `SMS_OFF_STATUS, 16'h0000);
    apb(1'b1, `SMS_OFF_CTRL2, c2);
    apb(1'b1, `SMS_OFF_CTRL1, c1);
    apb(1'b1, `SMS_OFF_STATUS, 16'h8000);
    @(posedge clock_i);
    ld <= 1'b1;
    pw <= 16'h0000;
    @(posedge clock_i);
    ld <= 1'b0;
  endtask
  task automatic load(input logic [15:0] w);
    @(posedge clock_i);
    ld <= 1'b1;
    pw <= w;
    @(posedge clock_i);
    ld <= 1'b0;
  endtask
  // counts clock toggles, period, frame pulse and irqs; stop ends on transfer irq
  task automatic watch(input int n, input bit stop);
    logic p;
    int c;
    tg = 0; per = 0; fs = 0; ei = 0; ti = 0; c = -1;
    p = sck;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_i);
      if (eirq === 1'b1) ei = 1;
      if (ss_o === 1'b0 && tg == 0) fs = 1;
      if (sck !== p) tg++;
      if (sck === 1'b1 && p === 1'b0) begin
        if (c >= 0 && per == 0) per = i - c;
        c = i;
      end
      p = sck;
      if (tirq === 1'b1) begin
        ti = 1;
        if (stop) return;
      end
    end
    if (stop) begin `CHK("irq wait", 1, 0) test_done(); end
  endtask
  task automatic t_regs();
    rd(`SMS_OFF_STATUS, 16'h0000, "stat rst");
    rd(`SMS_OFF_CTRL1, 16'h0000, "c1 rst");
    rd(`SMS_OFF_CTRL2, 16'h0000, "c2 rst");
    apb(1'b1, `SMS_OFF_CTRL1, 16'hFFFF);
    rd(`SMS_OFF_CTRL1, 16'h1FFF, "c1 bits");
    apb(1'b1, `SMS_OFF_CTRL2, 16'hE002);
    rd(`SMS_OFF_CTRL2, 16'hE002, "c2 bits");
    apb(1'b0, 4'h2, 16'h0000);
    `CHK("slverr", 1'b1, e)
    `CHK("err data", 32'h0, q)
  endtask
  task automatic t_rate(input logic [1:0] p, input logic [2:0] s, input int d);
    cfg(16'h0120 | {11'h000, s, p}, 16'h0000);
    load(16'h9600);
    apb(1'b1, `SMS_OFF_DATA, 16'h00C3);
    watch(4000, 1'b1);
    `CHK("sck period", d, per)
    `CHK("toggles", 16, tg)
    `CHK("peer rx", 8'hC3, prx[7:0])
    rd(`SMS_OFF_STATUS, 16'h8001, "rbf set");
    rd(`SMS_OFF_DATA, 16'h0096, "rx byte");
    rd(`SMS_OFF_STATUS, 16'h8000, "rbf clr");
  endtask
  task automatic t_ovf();
    cfg(16'h053E, 16'h0000);
    load(16'hBEEF);
    apb(1'b1, `SMS_OFF_DATA, 16'h1234);
    // watch from the first clock edge while the second word is queued
    fork
      watch(1000, 1'b1);
      begin
        apb(1'b1, `SMS_OFF_DATA, 16'h5A5A);
        rd(`SMS_OFF_STATUS, 16'h8002, "tbf set");
      end
    join
    `CHK("toggles16", 32, tg)
    rd(`SMS_OFF_STATUS, 16'h8001, "tbf clr");
    watch(150, 1'b0);
    `CHK("err irq", 1, ei)
    `CHK("peer rx", 16'h5A5A, prx)
    rd(`SMS_OFF_STATUS, 16'h8041, "ovf set");
    apb(1'b1, `SMS_OFF_DATA, 16'h0F0F);
    load(16'h3C3C);
    watch(200, 1'b0);
    `CHK("halted", 0, tg)
    rd(`SMS_OFF_DATA, 16'hBEEF, "kept word");
    watch(1000, 1'b1);
    rd(`SMS_OFF_DATA, 16'h3C3C, "rx after");
    apb(1'b1, `SMS_OFF_STATUS, 16'h8040);
    rd(`SMS_OFF_STATUS, 16'h8040, "w1 keeps");
    apb(1'b1, `SMS_OFF_STATUS, 16'h8000);
    rd(`SMS_OFF_STATUS, 16'h8000, "w0 clears");
  endtask
  task automatic t_pins();
    cfg(16'h0060, 16'h0000);
    repeat (2) @(negedge clock_i);
    `CHK("sck idle", 1'b1, sck)
    `CHK("sck oe", 1'b1, sck_oe)
    `CHK("sdo oe", 1'b1, sdo_oe)
    apb(1'b1, `SMS_OFF_CTRL1, 16'h1860);
    @(negedge clock_i);
    `CHK("sck off", 1'b0, sck_oe)
    `CHK("sdo off", 1'b0, sdo_oe)
    apb(1'b1, `SMS_OFF_CTRL1, 16'h0040);
    @(negedge clock_i);
    `CHK("slave sck", 1'b0, sck_oe)
    apb(1'b1, `SMS_OFF_STATUS, 16'h0000);
    apb(1'b1, `SMS_OFF_CTRL1, 16'h0060);
    @(negedge clock_i);
    `CHK("disabled", 1'b0, sck_oe)
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock_i);
      ssck <= 1'b1;
      repeat (4) @(posedge clock_i);
      ssck <= 1'b0;
    end
  endtask
  task automatic t_slave();
    // edge bit set, so select-enable is set too
    cfg(16'h0180, 16'h0000);
    apb(1'b1, `SMS_OFF_DATA, 16'h00A5);
    pulse(8);
    `CHK("sdo sel", 1'b0, sdo_oe)
    rd(`SMS_OFF_STATUS, 16'h8000, "no sel");
    load(16'h6900);
    ssel <= 1'b0;
    pulse(8);
    `CHK("slave tx", 8'hA5, prx[7:0])
    rd(`SMS_OFF_DATA, 16'h0069, "slave rx");
    ssel <= 1'b1;
  endtask
  task automatic t_frame();
    // edge bit kept zero while framed
    cfg(16'h003E, 16'h8000);
    @(negedge clock_i);
    `CHK("fs oe", 1'b1, ss_oe)
    `CHK("fs idle", 1'b1, ss_o)
    apb(1'b1, `SMS_OFF_DATA, 16'h00AA);
    watch(1000, 1'b1);
    `CHK("fs first", 1, fs)
    apb(1'b0, `SMS_OFF_DATA, 16'h0000);
    apb(1'b1, `SMS_OFF_CTRL2, 16'hA000);
    @(negedge clock_i);
    `CHK("fs high pol", 1'b0, ss_o)
    apb(1'b1, `SMS_OFF_CTRL2, 16'hC000);
    @(negedge clock_i);
    `CHK("fs input", 1'b0, ss_oe)
  endtask
  task automatic t_idle();
    cfg(16'h033E, 16'h0000);
    apb(1'b1, `SMS_OFF_STATUS, 16'hA000);
    idle <= 1'b1;
    load(16'h7100);
    apb(1'b1, `SMS_OFF_DATA, 16'h0055);
    watch(200, 1'b0);
    `CHK("idle halt", 0, tg)
    @(posedge clock_i);
    idle <= 1'b0;
    watch(1000, 1'b1);
    rd(`SMS_OFF_DATA, 16'h0071, "idle rx");
  endtask
  initial begin
    {psel, penable, pwrite, idle, ld, ssck, ssel} = 7'h01;
    paddr = 4'h0;
    pwdata = 32'h0;
    pw = 16'h0000;
    error_cnt = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    // idle mode held with idle-stop clear: the port keeps running
    idle <= 1'b1;
    // valid pairs only: primary 1:1 never with secondary 1:1 or 2:1
    t_rate(2'b10, 3'b111, 4);
    t_rate(2'b11, 3'b000, 8);
    t_rate(2'b01, 3'b110, 32);
    t_rate(2'b00, 3'b111, 64);
    t_rate(2'b10, 3'b101, 12);
    idle <= 1'b0;
    t_ovf();
    t_pins();
    t_slave();
    t_frame();
    t_idle();
    test_done();
  end
endmodule
